// [include/tcc_pkg.sv]
// package: register map, field positions and constants of the capture/compare timer
package tcc_pkg;
    // register byte addresses (no map is printed, so these are chosen)
    localparam logic [4:0] ADR_CTRL_A = 5'h00;
    localparam logic [4:0] ADR_CTRL_B = 5'h01;
    localparam logic [4:0] ADR_STATUS = 5'h02;
    localparam logic [4:0] ADR_CAP1_HI = 5'h03;
    localparam logic [4:0] ADR_CAP1_LO = 5'h04;
    localparam logic [4:0] ADR_CMP1_HI = 5'h05;
    localparam logic [4:0] ADR_CMP1_LO = 5'h06;
    localparam logic [4:0] ADR_CNT_HI = 5'h07;
    localparam logic [4:0] ADR_CNT_LO = 5'h08;
    localparam logic [4:0] ADR_SHD_HI = 5'h09;
    localparam logic [4:0] ADR_SHD_LO = 5'h0a;
    localparam logic [4:0] ADR_CAP2_HI = 5'h0b;
    localparam logic [4:0] ADR_CAP2_LO = 5'h0c;
    localparam logic [4:0] ADR_CMP2_HI = 5'h0d;
    localparam logic [4:0] ADR_CMP2_LO = 5'h0e;
    // control a fields
    localparam int CA_CAP_IRQ_EN = 7;
    localparam int CA_CMP_IRQ_EN = 6;
    localparam int CA_OVF_IRQ_EN = 5;
    localparam int CA_CAP_EDGE1 = 1;
    // control b fields
    localparam int CB_CMP_PIN_EN1 = 7;
    localparam int CB_CMP_PIN_EN2 = 6;
    localparam int CB_ONE_PULSE = 5;
    localparam int CB_PWM = 4;
    localparam int CB_CLK_SEL_HI = 3;
    localparam int CB_CLK_SEL_LO = 2;
    localparam int CB_CAP_EDGE2 = 1;
    localparam int CB_EXT_EDGE = 0;
    // status fields
    localparam int ST_CAP1 = 7;
    localparam int ST_CMP1 = 6;
    localparam int ST_OVF = 5;
    localparam int ST_CAP2 = 4;
    localparam int ST_CMP2 = 3;
    // reset values and clock selects
    localparam logic [15:0] CNT_RELOAD = 16'hfffc;
    localparam logic [15:0] CNT_TOP = 16'hffff;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] CLK_DIV4 = 2'b00;
    localparam logic [1:0] CLK_DIV2 = 2'b01;
    localparam logic [1:0] CLK_DIV8 = 2'b10;
    localparam logic [1:0] CLK_EXT = 2'b11;
    localparam logic [2:0] PRE_MASK2 = 3'h1;
    localparam logic [2:0] PRE_MASK4 = 3'h3;
    localparam logic [2:0] PRE_MASK8 = 3'h7;
    localparam logic [2:0] PRE_ONE = 3'h1;
endpackage

// [hw/tcc_timer.sv]
// 16-bit free-running timer with two input captures and two output compares
// Operation
// - 16-bit up-only counter, every 16-bit register reached as high and low byte
// - two read views of the count; shadow low byte never clears overflow
// - counter low byte write reloads fffc; fffc is reset and only reload value
// - timer tick is cpu clock divided by 2, 4, 8 or external clock
// - clock select both ones picks external pin; edge bit chooses its edge
// - all counter updates synchronous to the one internal clock
// - high byte read freezes low byte until low byte is read
// - after a completed pair, lone low byte read returns live count
// - overflow flag set when counter wraps ffff to 0000
// - overflow request when flag, enable set and global mask clear
// - overflow flag clears by status read then main low byte access
// - counter runs in wait, holds in halt, resumes held count
// - capture pin edge latches count and sets capture flag
// - each capture channel has its own edge select bit
// - one shared capture enable gates both capture flags onto request
// - capture flag clears by status read then that capture low byte access
// - capture high byte read blocks captures until low byte read
// - one-pulse or pwm mode leaves only capture channel 2 and compare channel 2 working
// - capture pins always feed capture logic, whatever pin direction
// - compare every tick; match sets flag, drives pin, may interrupt
// - compare registers software only, reset to 8000
// - divide-by-2 matches on equal; other clocks on compare plus one
// - compare high write inhibits until low write; flag clears by status then low
`timescale 1ns/10ps
module tcc_timer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic global_irq_mask,
    input wire logic halt_mode,
    input wire logic ext_count_pin,
    input wire logic capture_pin_1,
    input wire logic capture_pin_2,
    output logic compare_pin_1,
    output logic compare_pin_2,
    output logic compare_pin_en_1,
    output logic compare_pin_en_2,
    output logic timer_irq
);
    import tcc_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [15:0] count_q;
    logic [2:0] pre_q;
    logic [7:0] low_buf_q;
    logic low_frozen_q;
    logic [15:0] cap1_q;
    logic [15:0] cap2_q;
    logic [7:0] cap1_lo_buf_q;
    logic [7:0] cap2_lo_buf_q;
    logic cap1_block_q;
    logic cap2_block_q;
    logic [15:0] cmp1_q;
    logic [15:0] cmp2_q;
    logic cmp1_inhibit_q;
    logic cmp2_inhibit_q;
    logic ovf_q;
    logic cap1_flag_q;
    logic cap2_flag_q;
    logic cmp1_flag_q;
    logic cmp2_flag_q;
    logic ovf_armed_q;
    logic cap1_armed_q;
    logic cap2_armed_q;
    logic cmp1_armed_q;
    logic cmp2_armed_q;
    logic cmp1_out_q;
    logic cmp2_out_q;
    logic [7:0] rdata_q;
    logic [2:0] ext_sync_q;
    logic [2:0] cap1_sync_q;
    logic [2:0] cap2_sync_q;

    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ref_a);
        hit = (a == ref_a);
    endfunction

    wire any_acc = reg_wr | reg_rd;
    wire cnt_lo_acc = any_acc & hit(reg_addr, ADR_CNT_LO);
    wire cnt_lo_rd = reg_rd & (hit(reg_addr, ADR_CNT_LO) | hit(reg_addr, ADR_SHD_LO));
    wire cnt_hi_rd = reg_rd & (hit(reg_addr, ADR_CNT_HI) | hit(reg_addr, ADR_SHD_HI));
    wire cnt_lo_wr = reg_wr & (hit(reg_addr, ADR_CNT_LO) | hit(reg_addr, ADR_SHD_LO));
    wire stat_rd = reg_rd & hit(reg_addr, ADR_STATUS);
    wire cap1_hi_rd = reg_rd & hit(reg_addr, ADR_CAP1_HI);
    wire cap2_hi_rd = reg_rd & hit(reg_addr, ADR_CAP2_HI);
    wire cap1_lo_rd = reg_rd & hit(reg_addr, ADR_CAP1_LO);
    wire cap2_lo_rd = reg_rd & hit(reg_addr, ADR_CAP2_LO);
    wire cap1_lo_acc = any_acc & hit(reg_addr, ADR_CAP1_LO);
    wire cap2_lo_acc = any_acc & hit(reg_addr, ADR_CAP2_LO);
    wire cmp1_hi_wr = reg_wr & hit(reg_addr, ADR_CMP1_HI);
    wire cmp2_hi_wr = reg_wr & hit(reg_addr, ADR_CMP2_HI);
    wire cmp1_lo_wr = reg_wr & hit(reg_addr, ADR_CMP1_LO);
    wire cmp2_lo_wr = reg_wr & hit(reg_addr, ADR_CMP2_LO);
    wire cmp1_lo_acc = any_acc & hit(reg_addr, ADR_CMP1_LO);
    wire cmp2_lo_acc = any_acc & hit(reg_addr, ADR_CMP2_LO);

    // -------------------------------------------------------------
    // timer tick
    // -------------------------------------------------------------
    wire [1:0] clk_sel = ctrl_b_q[CB_CLK_SEL_HI:CB_CLK_SEL_LO];
    wire ext_mode = (clk_sel == CLK_EXT);
    wire alt_mode = ctrl_b_q[CB_ONE_PULSE] | ctrl_b_q[CB_PWM];
    // edge detection reads only the second and third stages
    wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
    wire ext_fall = ~ext_sync_q[1] & ext_sync_q[2];
    wire ext_tick = ctrl_b_q[CB_EXT_EDGE] ? ext_rise : ext_fall;
    wire [2:0] pre_mask = (clk_sel == CLK_DIV2) ? PRE_MASK2 :
                          (clk_sel == CLK_DIV8) ? PRE_MASK8 : PRE_MASK4;
    wire pre_tick = ((pre_q & pre_mask) == pre_mask);
    // halt freezes prescaler and count; wait is invisible here
    wire tick = ~halt_mode & (ext_mode ? ext_tick : pre_tick);
    wire [15:0] count_inc = count_q + CNT_ONE;
    wire wrap = tick & (count_q == CNT_TOP);

    // -------------------------------------------------------------
    // capture edges, compare matches
    // -------------------------------------------------------------
    wire cap1_edge = ctrl_a_q[CA_CAP_EDGE1] ? (cap1_sync_q[1] & ~cap1_sync_q[2]) :
                     (~cap1_sync_q[1] & cap1_sync_q[2]);
    wire cap2_edge = ctrl_b_q[CB_CAP_EDGE2] ? (cap2_sync_q[1] & ~cap2_sync_q[2]) :
                     (~cap2_sync_q[1] & cap2_sync_q[2]);
    wire cap1_take = cap1_edge & ~cap1_block_q & ~alt_mode;
    wire cap2_take = cap2_edge & ~cap2_block_q;
    // divide-by-2 matches the count itself, slower clocks one tick later
    wire div2 = (clk_sel == CLK_DIV2);
    wire [15:0] cmp1_ref = div2 ? cmp1_q : cmp1_q + CNT_ONE;
    wire [15:0] cmp2_ref = div2 ? cmp2_q : cmp2_q + CNT_ONE;
    wire cmp1_hit = tick & ~cmp1_inhibit_q & ~alt_mode & (count_q == cmp1_ref);
    wire cmp2_hit = tick & ~cmp2_inhibit_q & (count_q == cmp2_ref);

    // -------------------------------------------------------------
    // synchronisers for the three pins
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_sync_q <= 3'h0;
            cap1_sync_q <= 3'h0;
            cap2_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_count_pin};
            cap1_sync_q <= {cap1_sync_q[1:0], capture_pin_1};
            cap2_sync_q <= {cap2_sync_q[1:0], capture_pin_2};
        end
    end

    // -------------------------------------------------------------
    // control registers and counter
    // -------------------------------------------------------------
    // reload wins over a tick so software always sees fffc after the write
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_a_q <= CTRL_RESET;
            ctrl_b_q <= CTRL_RESET;
            count_q <= CNT_RELOAD;
            pre_q <= 3'h0;
        end else begin
            if (reg_wr & hit(reg_addr, ADR_CTRL_A)) ctrl_a_q <= reg_wdata;
            if (reg_wr & hit(reg_addr, ADR_CTRL_B)) ctrl_b_q <= reg_wdata;
            if (!halt_mode) pre_q <= pre_q + PRE_ONE;
            if (cnt_lo_wr) count_q <= CNT_RELOAD;
            else if (tick) count_q <= count_inc;
        end
    end

    // -------------------------------------------------------------
    // counter read pairing
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_buf_q <= 8'h00;
            low_frozen_q <= 1'b0;
        end else if (cnt_hi_rd) begin
            if (!low_frozen_q) low_buf_q <= count_q[7:0];
            low_frozen_q <= 1'b1;
        end else if (cnt_lo_rd) begin
            low_frozen_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // capture registers
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap1_q <= 16'h0000;
            cap2_q <= 16'h0000;
            cap1_block_q <= 1'b0;
            cap2_block_q <= 1'b0;
            cap1_lo_buf_q <= 8'h00;
            cap2_lo_buf_q <= 8'h00;
        end else begin
            if (cap1_take) cap1_q <= count_q;
            if (cap2_take) cap2_q <= count_q;
            if (cap1_hi_rd) cap1_lo_buf_q <= cap1_q[7:0];
            if (cap2_hi_rd) cap2_lo_buf_q <= cap2_q[7:0];
            if (cap1_hi_rd) cap1_block_q <= 1'b1;
            else if (cap1_lo_rd) cap1_block_q <= 1'b0;
            if (cap2_hi_rd) cap2_block_q <= 1'b1;
            else if (cap2_lo_rd) cap2_block_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // compare registers, written only by software
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp1_q <= CMP_RESET;
            cmp2_q <= CMP_RESET;
            cmp1_inhibit_q <= 1'b0;
            cmp2_inhibit_q <= 1'b0;
        end else begin
            if (cmp1_hi_wr) cmp1_q[15:8] <= reg_wdata;
            if (cmp1_lo_wr) cmp1_q[7:0] <= reg_wdata;
            if (cmp2_hi_wr) cmp2_q[15:8] <= reg_wdata;
            if (cmp2_lo_wr) cmp2_q[7:0] <= reg_wdata;
            if (cmp1_hi_wr) cmp1_inhibit_q <= 1'b1;
            else if (cmp1_lo_wr) cmp1_inhibit_q <= 1'b0;
            if (cmp2_hi_wr) cmp2_inhibit_q <= 1'b1;
            else if (cmp2_lo_wr) cmp2_inhibit_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // flags: a status read arms the clear, the low byte access clears
    // -------------------------------------------------------------
    // set beats clear, so an event in the clearing cycle survives
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_q <= 1'b0;
            cap1_flag_q <= 1'b0;
            cap2_flag_q <= 1'b0;
            cmp1_flag_q <= 1'b0;
            cmp2_flag_q <= 1'b0;
            ovf_armed_q <= 1'b0;
            cap1_armed_q <= 1'b0;
            cap2_armed_q <= 1'b0;
            cmp1_armed_q <= 1'b0;
            cmp2_armed_q <= 1'b0;
        end else begin
            ovf_q <= wrap | (ovf_q & ~(ovf_armed_q & cnt_lo_acc));
            cap1_flag_q <= cap1_take | (cap1_flag_q & ~(cap1_armed_q & cap1_lo_acc));
            cap2_flag_q <= cap2_take | (cap2_flag_q & ~(cap2_armed_q & cap2_lo_acc));
            cmp1_flag_q <= cmp1_hit | (cmp1_flag_q & ~(cmp1_armed_q & cmp1_lo_acc));
            cmp2_flag_q <= cmp2_hit | (cmp2_flag_q & ~(cmp2_armed_q & cmp2_lo_acc));
            if (stat_rd) ovf_armed_q <= ovf_q;
            else if (cnt_lo_acc) ovf_armed_q <= 1'b0;
            if (stat_rd) cap1_armed_q <= cap1_flag_q;
            else if (cap1_lo_acc) cap1_armed_q <= 1'b0;
            if (stat_rd) cap2_armed_q <= cap2_flag_q;
            else if (cap2_lo_acc) cap2_armed_q <= 1'b0;
            if (stat_rd) cmp1_armed_q <= cmp1_flag_q;
            else if (cmp1_lo_acc) cmp1_armed_q <= 1'b0;
            if (stat_rd) cmp2_armed_q <= cmp2_flag_q;
            else if (cmp2_lo_acc) cmp2_armed_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // compare pins: match toggles the pin, reset clears it to low
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp1_out_q <= 1'b0;
            cmp2_out_q <= 1'b0;
        end else begin
            if (cmp1_hit) cmp1_out_q <= ~cmp1_out_q;
            if (cmp2_hit) cmp2_out_q <= ~cmp2_out_q;
        end
    end
    assign compare_pin_1 = cmp1_out_q;
    assign compare_pin_2 = cmp2_out_q;
    assign compare_pin_en_1 = ctrl_b_q[CB_CMP_PIN_EN1];
    assign compare_pin_en_2 = ctrl_b_q[CB_CMP_PIN_EN2];

    // -------------------------------------------------------------
    // interrupt request; pending flags wait for the mask to open
    // -------------------------------------------------------------
    wire ovf_req = ovf_q & ctrl_a_q[CA_OVF_IRQ_EN];
    wire cap_req = (cap1_flag_q | cap2_flag_q) & ctrl_a_q[CA_CAP_IRQ_EN];
    wire cmp_req = (cmp1_flag_q | cmp2_flag_q) & ctrl_a_q[CA_CMP_IRQ_EN];
    assign timer_irq = ~global_irq_mask & (ovf_req | cap_req | cmp_req);

    // -------------------------------------------------------------
    // read mux, registered for next-cycle data
    // -------------------------------------------------------------
    wire [7:0] status_byte = {cap1_flag_q, cmp1_flag_q, ovf_q, cap2_flag_q, cmp2_flag_q, 3'h0};
    wire [7:0] cnt_lo_view = low_frozen_q ? low_buf_q : count_q[7:0];
    wire [7:0] cap1_lo_view = cap1_block_q ? cap1_lo_buf_q : cap1_q[7:0];
    wire [7:0] cap2_lo_view = cap2_block_q ? cap2_lo_buf_q : cap2_q[7:0];
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ADR_CTRL_A: rd_mux = ctrl_a_q;
            ADR_CTRL_B: rd_mux = ctrl_b_q;
            ADR_STATUS: rd_mux = status_byte;
            ADR_CAP1_HI: rd_mux = cap1_q[15:8];
            ADR_CAP1_LO: rd_mux = cap1_lo_view;
            ADR_CMP1_HI: rd_mux = cmp1_q[15:8];
            ADR_CMP1_LO: rd_mux = cmp1_q[7:0];
            ADR_CNT_HI: rd_mux = count_q[15:8];
            ADR_CNT_LO: rd_mux = cnt_lo_view;
            ADR_SHD_HI: rd_mux = count_q[15:8];
            ADR_SHD_LO: rd_mux = cnt_lo_view;
            ADR_CAP2_HI: rd_mux = cap2_q[15:8];
            ADR_CAP2_LO: rd_mux = cap2_lo_view;
            ADR_CMP2_HI: rd_mux = cmp2_q[15:8];
            ADR_CMP2_LO: rd_mux = cmp2_q[7:0];
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) rdata_q <= 8'h00;
        else rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
    assign reg_rdata = rdata_q;
endmodule // tcc_timer

// [verification/tcc_timer_properties.sv]
// checker: port-level assertions for the capture/compare timer
`timescale 1ns/10ps
module tcc_timer_properties
    import tcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic global_irq_mask,
    input wire logic halt_mode,
    input wire logic compare_pin_1,
    input wire logic compare_pin_en_1,
    input wire logic compare_pin_en_2,
    input wire logic timer_irq
);
    logic [7:0] ctla_q;
    // copy of control a, so the checker knows which requests are enabled
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctla_q <= CTRL_RESET;
        end else if (reg_wr && reg_addr == ADR_CTRL_A) begin
            ctla_q <= reg_wdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // bus, pins and request
    // ------------------------------------------------------------
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_unmapped_zero: assert property (reg_rd && reg_addr > ADR_CMP2_LO |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_cmp_readback: assert property (reg_wr && reg_addr == ADR_CMP1_HI ##1 reg_rd && reg_addr == ADR_CMP1_HI
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("compare high byte not read back");
    a_pin_en_set: assert property (reg_wr && reg_addr == ADR_CTRL_B
        |=> {compare_pin_en_1, compare_pin_en_2} == $past(reg_wdata[7:6]))
        else $error("pin enables do not follow control b");
    a_pin_en_hold: assert property (!(reg_wr && reg_addr == ADR_CTRL_B)
        |=> $stable(compare_pin_en_1) && $stable(compare_pin_en_2))
        else $error("pin enable moved without write");
    a_irq_masked: assert property (global_irq_mask |-> !timer_irq)
        else $error("request while globally masked");
    a_irq_disabled: assert property (ctla_q[7:5] == 3'b000 |-> !timer_irq)
        else $error("request with all enables clear");
    a_halt_freeze: assert property (halt_mode [*3] |-> $stable(compare_pin_1))
        else $error("compare pin moved in halt");
endmodule // tcc_timer_properties

// [verification/tcc_pin_model.sv]
// far-side pins: external count clock and two capture pins
`timescale 1ns/10ps
module tcc_pin_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ext_run,
    input wire logic [1:0] cap_set,
    output logic ext_count_pin,
    output logic capture_pin_1,
    output logic capture_pin_2
);
    logic [1:0] ph_q;
    // toggles every 4 clocks, so like edges are 8 apart; stands still when not running
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_q <= 2'b00;
            ext_count_pin <= 1'b0;
        end else if (ext_run) begin
            ph_q <= ph_q + 2'b01;
            if (ph_q == 2'b11) ext_count_pin <= ~ext_count_pin;
        end
    end
    // capture pins follow the requested levels one clock late
    always_ff @(posedge sys_clk) begin
        capture_pin_1 <= cap_set[0];
        capture_pin_2 <= cap_set[1];
    end
endmodule // tcc_pin_model

// [verification/tcc_timer_tb.sv]
// testbench: bus, rate, flag and capture scenarios for the capture/compare timer
`timescale 1ns/10ps
module tcc_timer_tb;
    import tcc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic mask = 1'b0;
    logic halt = 1'b1;
    logic ext_run = 1'b0;
    logic [1:0] cap_set = 2'b00;
    logic [7:0] rdata, b, h, l, a;
    logic ext_pin, cap1, cap2, pin1, pin2, en1, en2, irq, pv, pw;
    logic [31:0] seed = 32'h7128c20a;
    logic [15:0] v0, v1;
    logic [4:0] ca;
    int bad_count = 0;
    int check_count = 0;
    int i, n;
    logic [4:0] ra [10] = '{ADR_CNT_HI, ADR_CNT_LO, ADR_SHD_HI, ADR_SHD_LO, ADR_CMP1_HI, ADR_CMP1_LO,
        ADR_CMP2_HI, ADR_CMP2_LO, ADR_CTRL_B, 5'h1f};
    logic [7:0] re [10] = '{8'hff, 8'hfc, 8'hff, 8'hfc, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [15:0] per [4] = '{16'h10, 16'h20, 16'h08, 16'h08};
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    tcc_timer u_tcc_timer (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .global_irq_mask(mask), .halt_mode(halt),
        .ext_count_pin(ext_pin), .capture_pin_1(cap1), .capture_pin_2(cap2), .compare_pin_1(pin1),
        .compare_pin_2(pin2), .compare_pin_en_1(en1), .compare_pin_en_2(en2), .timer_irq(irq));
    tcc_pin_model u_tcc_pin_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .ext_run(ext_run),
        .cap_set(cap_set), .ext_count_pin(ext_pin), .capture_pin_1(cap1), .capture_pin_2(cap2));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // strobes are left up so writes can run back to back
    task automatic wr(input logic [4:0] ad, input logic [7:0] d);
        addr <= ad;
        wdata <= d;
        wr_s <= 1'b1;
        rd_s <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic idle(input int c);
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        repeat (c) @(posedge sys_clk);
    endtask
    // data is taken at the edge closing the answer cycle
    task automatic rd(input logic [4:0] ad, output logic [7:0] d);
        addr <= ad;
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        @(posedge sys_clk);
        idle(1);
        d = rdata;
    endtask
    task automatic rd16(input logic [4:0] ah, output logic [15:0] v);
        logic [7:0] x, y;
        rd(ah, x);
        rd(ah + 5'h01, y);
        v = {x, y};
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        // reset values, counter held by halt
        for (i = 0; i < 10; i++) begin
            rd(ra[i], b);
            chk(b, re[i]);
        end
        // random compare values, high read back before the low write
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            ca = i[0] ? ADR_CMP2_HI : ADR_CMP1_HI;
            wr(ca, seed[15:8]);
            rd(ca, b);
            chk(b, seed[15:8]);
            wr(ca + 5'h01, seed[7:0]);
            rd(ca + 5'h01, b);
            chk(b, seed[7:0]);
        end
        // counts over 64 clocks for each clock select
        halt <= 1'b0;
        ext_run <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(ADR_CTRL_B, {4'h0, i[1:0], 2'b01});
            idle(4);
            rd16(ADR_CNT_HI, v0);
            idle(60);
            rd16(ADR_CNT_HI, v1);
            chk(v1 - v0, per[i]);
        end
        // overflow: reload, clear old flag, wrap under div2
        halt <= 1'b1;
        wr(ADR_CTRL_B, 8'h04);
        wr(ADR_CNT_LO, 8'h00);
        rd(ADR_STATUS, b);
        rd(ADR_CNT_LO, b);
        rd(ADR_STATUS, b);
        chk(b[5], 1'b0);
        halt <= 1'b0;
        for (n = 0; n < 20 && b[5] !== 1'b1; n++) rd(ADR_STATUS, b);
        chk(b[5], 1'b1);
        if (b[5] !== 1'b1) end_of_test();
        chk(irq, 1'b0);
        wr(ADR_CTRL_A, 8'h20);
        idle(1);
        chk(irq, 1'b1);
        mask <= 1'b1;
        idle(1);
        chk(irq, 1'b0);
        mask <= 1'b0;
        rd(ADR_STATUS, b);
        rd(ADR_SHD_LO, b);
        rd(ADR_STATUS, b);
        chk(b[5], 1'b1);
        rd(ADR_CNT_LO, b);
        rd(ADR_STATUS, b);
        chk({b[5], irq}, 2'b00);
        // lone low reads around exactly 16 running clocks
        halt <= 1'b1;
        idle(2);
        rd(ADR_CNT_LO, a);
        halt <= 1'b0;
        idle(16);
        halt <= 1'b1;
        idle(2);
        rd(ADR_CNT_LO, b);
        chk(b, 8'(a + 8'h08));
        // low byte stays frozen across a second high read
        rd(ADR_CNT_HI, h);
        halt <= 1'b0;
        idle(20);
        rd(ADR_CNT_HI, h);
        rd(ADR_CNT_LO, l);
        chk(l, b);
        // captures with the count held at the reload value
        halt <= 1'b1;
        wr(ADR_CNT_LO, 8'h00);
        wr(ADR_CTRL_A, 8'h82);
        cap_set <= 2'b11;
        idle(6);
        rd(ADR_STATUS, b);
        chk({b[7], b[4], irq}, 3'b101);
        rd16(ADR_CAP1_HI, v0);
        chk(v0, 16'hfffc);
        rd(ADR_STATUS, b);
        chk({b[7], irq}, 2'b00);
        cap_set <= 2'b01;
        idle(6);
        rd(ADR_STATUS, b);
        chk(b[4], 1'b1);
        rd(ADR_CAP1_HI, h);
        cap_set <= 2'b00;
        idle(6);
        cap_set <= 2'b01;
        idle(6);
        rd(ADR_STATUS, b);
        chk(b[7], 1'b0);
        rd(ADR_CAP1_LO, l);
        // one-pulse mode leaves capture 1 deaf to a rising pin
        wr(ADR_CTRL_B, 8'h24);
        cap_set <= 2'b00;
        idle(6);
        cap_set <= 2'b01;
        idle(6);
        rd(ADR_STATUS, b);
        chk(b[7], 1'b0);
        // compare match on both channels toggles the pins and sets the flags
        wr(ADR_CTRL_B, 8'hc4);
        wr(ADR_CMP1_HI, 8'hff);
        wr(ADR_CMP1_LO, 8'hfe);
        wr(ADR_CMP2_HI, 8'hff);
        wr(ADR_CMP2_LO, 8'hfe);
        rd(ADR_STATUS, b);
        rd(ADR_CMP1_LO, b);
        rd(ADR_CMP2_LO, b);
        pv = pin1;
        pw = pin2;
        halt <= 1'b0;
        idle(12);
        rd(ADR_STATUS, b);
        chk({b[6], b[3], pin1, pin2}, {2'b11, ~pv, ~pw});
        end_of_test();
    end
endmodule // tcc_timer_tb
bind tcc_timer tcc_timer_properties u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_mask(global_irq_mask), .halt_mode(halt_mode), .compare_pin_1(compare_pin_1),
    .compare_pin_en_1(compare_pin_en_1), .compare_pin_en_2(compare_pin_en_2), .timer_irq(timer_irq));
